// ==== special_image_map.svh ====
// Register map, field positions, reset values and timing counts of the special image block.
// What this block does, and what software must do
// R1 - Window code sets hold time, 16 to 512
// R2 - Code zero releases bus after first transaction
// R3 - Each coupled transaction restarts the full window
// R4 - Window expiry releases VMEbus ownership
// R5 - Software keeps window code steady during coupled cycles
// R6 - Software writes misc register only when idle
// R7 - Legacy retry bits are inert storage
// R8 - Fixed 64 Mbyte window, aligned base
// R9 - Claim when address bits 31:26 match base
// R10 - Other target images win over this one
// R11 - Address bits 25:24 pick one of four regions
// R12 - Top 64 Kbyte of region goes A16
// R13 - Program/data bit ignored for A16 accesses
// R14 - Never emit block transfer modifier codes
// R15 - Per-region width bit: 0 16-bit, 1 32-bit
// R16 - Per-region bit: 0 data, 1 program
// R17 - Per-region bit: 0 user, 1 supervisor
// R18 - Image decodes only while enabled
// R19 - Posted writes only while posted enable set
// R20 - Space bit: 0 memory, 1 I/O
// R21 - Region index selects width and modifier bits
`ifndef SPECIAL_IMAGE_MAP_SVH
`define SPECIAL_IMAGE_MAP_SVH

// ----------------------------------------------------------------
// Register offsets and reset values
// ----------------------------------------------------------------
`define MISC_OFFSET 12'h184
`define IMAGE_OFFSET 12'h188
`define MISC_RESET 32'h0000_0000
`define IMAGE_RESET 32'h0000_0000
`define MISC_RW_MASK 32'hf700_0000
`define IMAGE_RW_MASK 32'hc0f0_fffd

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RETRY_MSB 31
`define RETRY_LSB 28
`define CWT_MSB 26
`define CWT_LSB 24
`define EN_BIT 31
`define POSTED_WRITE_ENABLE_BIT 30
`define VDW_MSB 23
`define VDW_LSB 20
`define PGM_MSB 15
`define PGM_LSB 12
`define SUPER_MSB 11
`define SUPER_LSB 8
`define BS_MSB 7
`define BS_LSB 2
`define LAS_BIT 0

// ----------------------------------------------------------------
// Window timing and address modifier codes
// ----------------------------------------------------------------
`define CWT_DISABLE 3'h0
`define CWT_RESERVED 3'h7
`define WINDOW_MIN_CLOCKS 10'h010
`define A16_TOP_PAGE 8'hff
`define AM_A16_USER 6'h29
`define AM_A16_SUPER 6'h2d
`define AM_A24_USER_DATA 6'h39
`define AM_A24_USER_PROG 6'h3a
`define AM_A24_SUPER_DATA 6'h3d
`define AM_A24_SUPER_PROG 6'h3e
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3

`endif

// ==== special_image_pkg.sv ====
// Types shared by the special image block.
package special_image_pkg;

    typedef struct packed {
        logic [5:0] am;
        logic wide;
        logic a16;
        logic posted;
    } vme_attr_s;

    typedef enum logic [1:0] {
        WR_IDLE = 2'b01,
        WR_RESP = 2'b10
    } wr_state_e;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_DATA = 2'b10
    } rd_state_e;

    typedef enum logic [2:0] {
        OWN_IDLE = 3'b001,
        OWN_BUSY = 3'b010,
        OWN_HOLD = 3'b100
    } own_state_e;

endpackage

// ==== special_image_slave.sv ====
// Special target image decoder with coupled window timer and AXI4-Lite registers.
`timescale 1ns/1ps
`default_nettype none
`include "special_image_map.svh"

module special_image_slave
    import special_image_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic reqValid,
    input wire logic [31:0] reqAddr,
    input wire logic reqIo,
    input wire logic reqWrite,
    input wire logic otherImageHit,
    input wire logic coupledStart,
    input wire logic coupledDone,
    output logic claim,
    output vme_attr_s vmeAttr,
    output logic vmeOwned
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [31:0] misc_reg;
    logic [31:0] image_reg;
    wr_state_e wrState_reg;
    rd_state_e rdState_reg;
    own_state_e ownState_reg;
    logic awHave_reg;
    logic wHave_reg;
    logic [11:0] awAddr_reg;
    logic [31:0] wData_reg;
    logic [3:0] wStrb_reg;
    logic awFire;
    logic wFire;
    logic wrCommit;
    logic [11:0] wrAddr;
    logic [31:0] wrData;
    logic [3:0] wrStrb;
    logic [31:0] wrMerged_next;
    logic claim_next;
    vme_attr_s attr_next;
    logic [2:0] coupled_window_timer_field;
    logic [9:0] windowLen;
    logic [9:0] holdCount_reg;
    logic [1:0] region;
    logic imageEn;
    logic [5:0] imageBase;
    logic imageLas;
    logic [3:0] vdwBits;
    logic [3:0] pgmBits;
    logic [3:0] superBits;

    assign coupled_window_timer_field = misc_reg[`CWT_MSB:`CWT_LSB];
    assign imageEn = image_reg[`EN_BIT];
    assign imageBase = image_reg[`BS_MSB:`BS_LSB];
    assign imageLas = image_reg[`LAS_BIT];
    assign vdwBits = image_reg[`VDW_MSB:`VDW_LSB];
    assign pgmBits = image_reg[`PGM_MSB:`PGM_LSB];
    assign superBits = image_reg[`SUPER_MSB:`SUPER_LSB];

    // ----------------------------------------------------------------
    // Register write channel
    // ----------------------------------------------------------------
    assign awFire = s_axi_awvalid && s_axi_awready;
    assign wFire = s_axi_wvalid && s_axi_wready;
    assign wrCommit = (wrState_reg == WR_IDLE) && (awHave_reg || awFire) && (wHave_reg || wFire);
    assign wrAddr = awHave_reg ? awAddr_reg : s_axi_awaddr;
    assign wrData = wHave_reg ? wData_reg : s_axi_wdata;
    assign wrStrb = wHave_reg ? wStrb_reg : s_axi_wstrb;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            wrState_reg <= WR_IDLE;
            awHave_reg <= 1'b0;
            wHave_reg <= 1'b0;
            awAddr_reg <= 12'h000;
            wData_reg <= 32'h0000_0000;
            wStrb_reg <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end else begin
            unique case (wrState_reg)
                WR_IDLE: begin
                    if (awFire) begin
                        awAddr_reg <= s_axi_awaddr;
                    end
                    if (wFire) begin
                        wData_reg <= s_axi_wdata;
                        wStrb_reg <= s_axi_wstrb;
                    end
                    if (wrCommit) begin
                        awHave_reg <= 1'b0;
                        wHave_reg <= 1'b0;
                        s_axi_awready <= 1'b0;
                        s_axi_wready <= 1'b0;
                        s_axi_bvalid <= 1'b1;
                        if (wrAddr == `MISC_OFFSET || wrAddr == `IMAGE_OFFSET) begin
                            s_axi_bresp <= `RESP_OKAY;
                        end else begin
                            s_axi_bresp <= `RESP_DECERR;
                        end
                        wrState_reg <= WR_RESP;
                    end else begin
                        awHave_reg <= awHave_reg || awFire;
                        wHave_reg <= wHave_reg || wFire;
                        s_axi_awready <= !(awHave_reg || awFire);
                        s_axi_wready <= !(wHave_reg || wFire);
                    end
                end
                WR_RESP: begin
                    if (s_axi_bready) begin
                        s_axi_bvalid <= 1'b0;
                        s_axi_awready <= 1'b1;
                        s_axi_wready <= 1'b1;
                        wrState_reg <= WR_IDLE;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Register storage
    // ----------------------------------------------------------------
    always_comb begin
        wrMerged_next = (wrAddr == `MISC_OFFSET) ? misc_reg : image_reg;
        for (int b = 0; b < 4; b++) begin
            if (wrStrb[b]) begin
                wrMerged_next[b*8 +: 8] = wrData[b*8 +: 8];
            end
        end
    end

    // Window code changes while a coupled cycle runs are not guarded in hardware. // R5
    // The misc register is expected to change only while every image is off. // R6
    always_ff @(posedge core_clk) begin
        if (rst) begin
            misc_reg <= `MISC_RESET;
            image_reg <= `IMAGE_RESET;
        end else if (wrCommit) begin
            if (wrAddr == `MISC_OFFSET) begin
                misc_reg <= wrMerged_next & `MISC_RW_MASK; // R7
            end else if (wrAddr == `IMAGE_OFFSET) begin
                image_reg <= wrMerged_next & `IMAGE_RW_MASK; // R8
            end
        end
    end

    // ----------------------------------------------------------------
    // Register read channel
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdState_reg <= RD_IDLE;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_OKAY;
        end else begin
            unique case (rdState_reg)
                RD_IDLE: begin
                    if (s_axi_arvalid && s_axi_arready) begin
                        s_axi_arready <= 1'b0;
                        s_axi_rvalid <= 1'b1;
                        rdState_reg <= RD_DATA;
                        if (s_axi_araddr == `MISC_OFFSET) begin
                            s_axi_rdata <= misc_reg;
                            s_axi_rresp <= `RESP_OKAY;
                        end else if (s_axi_araddr == `IMAGE_OFFSET) begin
                            s_axi_rdata <= image_reg;
                            s_axi_rresp <= `RESP_OKAY;
                        end else begin
                            s_axi_rdata <= 32'h0000_0000;
                            s_axi_rresp <= `RESP_DECERR;
                        end
                    end else begin
                        s_axi_arready <= 1'b1;
                    end
                end
                RD_DATA: begin
                    if (s_axi_rready) begin
                        s_axi_rvalid <= 1'b0;
                        s_axi_arready <= 1'b1;
                        rdState_reg <= RD_IDLE;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Special image decode
    // ----------------------------------------------------------------
    // Decode is registered so that claim and attributes leave from flip-flops; the
    // cost is one cycle of latency behind the address.
    assign region = reqAddr[25:24]; // R11

    always_comb begin
        claim_next = reqValid && imageEn // R18
            && (reqAddr[31:26] == imageBase) // R9
            && (reqIo == imageLas) // R20
            && !otherImageHit; // R10
        attr_next.a16 = (reqAddr[23:16] == `A16_TOP_PAGE); // R12
        attr_next.wide = vdwBits[region]; // R15 R21
        attr_next.posted = image_reg[`POSTED_WRITE_ENABLE_BIT] && reqWrite && !reqIo; // R19
        if (attr_next.a16) begin
            attr_next.am = superBits[region] ? `AM_A16_SUPER : `AM_A16_USER; // R13 R17
        end else if (pgmBits[region]) begin
            attr_next.am = superBits[region] ? `AM_A24_SUPER_PROG : `AM_A24_USER_PROG; // R16
        end else begin
            attr_next.am = superBits[region] ? `AM_A24_SUPER_DATA : `AM_A24_USER_DATA; // R14
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            claim <= 1'b0;
            vmeAttr <= '0;
        end else begin
            claim <= claim_next;
            vmeAttr <= attr_next;
        end
    end

    // ----------------------------------------------------------------
    // Coupled window timer
    // ----------------------------------------------------------------
    // The reserved code behaves like code zero so a bad value never holds the bus.
    always_comb begin
        if (coupled_window_timer_field == `CWT_DISABLE || coupled_window_timer_field == `CWT_RESERVED) begin
            windowLen = 10'h000;
        end else begin
            windowLen = 10'(`WINDOW_MIN_CLOCKS << (coupled_window_timer_field - 3'h1)); // R1
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ownState_reg <= OWN_IDLE;
            holdCount_reg <= 10'h000;
            vmeOwned <= 1'b0;
        end else begin
            unique case (ownState_reg)
                OWN_IDLE: begin
                    if (coupledStart) begin
                        ownState_reg <= OWN_BUSY;
                        vmeOwned <= 1'b1;
                    end
                end
                OWN_BUSY: begin
                    if (coupledDone) begin
                        if (windowLen == 10'h000) begin
                            ownState_reg <= OWN_IDLE; // R2
                            vmeOwned <= 1'b0;
                        end else begin
                            ownState_reg <= OWN_HOLD;
                            holdCount_reg <= 10'(windowLen - 10'h001); // R3
                        end
                    end
                end
                OWN_HOLD: begin
                    if (coupledStart) begin
                        ownState_reg <= OWN_BUSY;
                    end else if (holdCount_reg == 10'h000) begin
                        ownState_reg <= OWN_IDLE; // R4
                        vmeOwned <= 1'b0;
                    end else begin
                        holdCount_reg <= 10'(holdCount_reg - 10'h001);
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_claim_enable: assert property (claim |-> $past(imageEn)) // R18
        else $error("Claim raised while the image was disabled.");
    a_base_match: assert property (claim |-> $past(reqAddr[31:26]) == $past(imageBase)) // R9
        else $error("Claim raised without a base match.");
    a_other_wins: assert property (reqValid && otherImageHit |=> !claim) // R10
        else $error("Special image claimed an access owned by another image.");
    a_space_match: assert property (claim |-> $past(reqIo) == $past(imageLas)) // R20
        else $error("Claim raised in the wrong space.");
    a_a16_top: assert property (claim |-> vmeAttr.a16 == ($past(reqAddr[23:16]) == 8'hff)) // R12
        else $error("A16 selection does not follow the top 64 Kbyte.");
    a_no_block: assert property (claim |-> vmeAttr.am[1:0] inside {2'b01, 2'b10}) // R14
        else $error("Block transfer modifier emitted.");
    a_a16_codes: assert property (claim && vmeAttr.a16 |-> vmeAttr.am inside {6'h29, 6'h2d}) // R13
        else $error("A16 modifier depends on the program bit.");
    a_width_pick: assert property (claim |-> vmeAttr.wide == $past(vdwBits[reqAddr[25:24]])) // R15
        else $error("Width bit not taken from the addressed region.");
    a_posted_gate: assert property (claim && vmeAttr.posted |-> $past(image_reg[30])) // R19
        else $error("Posted write without posted enable.");
    a_zero_release: assert property (ownState_reg == OWN_BUSY && coupledDone && coupled_window_timer_field == 3'h0
        |=> !vmeOwned) // R2
        else $error("Bus kept after a transaction with the window off.");
    a_window_load: assert property (ownState_reg == OWN_BUSY && coupledDone && coupled_window_timer_field == 3'h1
        |=> holdCount_reg == 10'h00f && vmeOwned) // R1
        else $error("Window not loaded with sixteen clocks.");
    a_expiry: assert property (ownState_reg == OWN_HOLD && holdCount_reg == 10'h000 && !coupledStart
        |=> !vmeOwned ##1 (!vmeOwned || $past(coupledStart))) // R4
        else $error("Bus not released at window expiry.");

    // A counter that slips by one cycle shortens every hold, so each step is checked.
    a_owned_state: assert property (vmeOwned == (ownState_reg != OWN_IDLE)) // R4
        else $error("Ownership flag out of step.");

    a_restart: assert property (ownState_reg == OWN_HOLD && coupledStart
        |=> ownState_reg == OWN_BUSY) // R3
        else $error("Window not restarted.");

    a_long_load: assert property (ownState_reg == OWN_BUSY && coupledDone && coupled_window_timer_field == 3'h6
        |=> holdCount_reg == 10'h1ff) // R1
        else $error("Longest window misloaded.");

    a_reserved_code: assert property (ownState_reg == OWN_BUSY && coupledDone && coupled_window_timer_field == 3'h7
        |=> !vmeOwned) // R1
        else $error("Reserved code held the bus.");

    a_hold_step: assert property (ownState_reg == OWN_HOLD && !coupledStart
        && holdCount_reg != 10'h000 |=> ownState_reg == OWN_HOLD
        && holdCount_reg == 10'($past(holdCount_reg) - 10'h001)) // R4
        else $error("Window count skipped.");

    a_count_bound: assert property (ownState_reg == OWN_HOLD |-> holdCount_reg < windowLen) // R1
        else $error("Window count too large.");

    a_claim_source: assert property (claim |-> $past(reqValid)) // R9
        else $error("Claim without a request.");

    a_base_miss: assert property (reqValid && reqAddr[31:26] != imageBase |=> !claim) // R9
        else $error("Claim outside the window.");

    a_off_silent: assert property (!imageEn |=> !claim) // R18
        else $error("Disabled image claimed.");

    a_space_miss: assert property (reqValid && reqIo != imageLas |=> !claim) // R20
        else $error("Claim in the wrong space.");

    a_prog_pick: assert property (claim && !vmeAttr.a16
        |-> vmeAttr.am[1] == $past(pgmBits[reqAddr[25:24]])) // R16 R21
        else $error("Program bit from wrong region.");

    a_super_pick: assert property (claim
        |-> vmeAttr.am[2] == $past(superBits[reqAddr[25:24]])) // R17 R21
        else $error("Privilege bit from wrong region.");

    a_posted_write: assert property (claim && vmeAttr.posted
        |-> $past(reqWrite) && !$past(reqIo)) // R19
        else $error("Posted flag on a read or I/O.");

    a_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("Write ready during a response.");

endmodule
`default_nettype wire

// ==== coupled_partner.sv ====
// Model of the far side that runs coupled VMEbus transactions for the slave channel.
`timescale 1ns/1ps
`default_nettype none

module coupled_partner (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic go,
    input wire logic [7:0] gap,
    output logic coupledStart,
    output logic coupledDone,
    output logic busy
);
    // ----------------------------------------------------------------
    // Transaction sequencing
    // ----------------------------------------------------------------
    // A start is refused while busy, so start and done always alternate.
    // The gap value sets how slowly the far side completes a transfer.
    logic [7:0] countReg;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            coupledStart <= 1'b0;
            coupledDone <= 1'b0;
            busy <= 1'b0;
            countReg <= 8'h00;
        end else begin
            coupledStart <= go && !busy;
            coupledDone <= busy && countReg == 8'h01;
            if (go && !busy) begin
                busy <= 1'b1;
                countReg <= gap;
            end else if (busy) begin
                countReg <= countReg - 8'h01;
                busy <= countReg != 8'h01;
            end
        end
    end
endmodule

`default_nettype wire

// ==== pci_slave_coupled_timer_special_image_bench.sv ====
// Self-checking bench for the special image decoder and coupled window timer.
`timescale 1ns/1ps
`default_nettype none
`include "special_image_map.svh"

module pci_slave_coupled_timer_special_image_bench import special_image_pkg::*;;
    // ----------------------------------------------------------------
    // Stimulus signals and design
    // ----------------------------------------------------------------
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic reqValid = 1'b0, reqIo = 1'b0, reqWrite = 1'b0, otherImageHit = 1'b0;
    logic [31:0] reqAddr = 32'h0;
    logic coupledStart, coupledDone, claim, vmeOwned, partnerBusy;
    vme_attr_s vmeAttr;
    logic go = 1'b0;
    logic [7:0] gap = 8'h01;
    int mismatches = 0, n_tests = 0, cycles = 0;

    special_image_slave i_special_image_slave (.core_clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .reqValid, .reqAddr, .reqIo,
        .reqWrite, .otherImageHit, .coupledStart, .coupledDone, .claim, .vmeAttr, .vmeOwned);
    coupled_partner i_coupled_partner (.core_clk, .rst, .go, .gap, .coupledStart,
        .coupledDone, .busy(partnerBusy));

    initial begin
        forever #10 core_clk = ~core_clk;
    end

    // The ceiling is well above the longest window sweep.
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 10000) begin
            mismatches = mismatches + 1;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("Counts: %0d comparisons, %0d mismatches", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // ----------------------------------------------------------------
    // Bus and port tasks
    // ----------------------------------------------------------------
    task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        logic awDone, wDone;
        awDone = 1'b0;
        wDone = 1'b0;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(awDone && wDone)) begin
            @(posedge core_clk);
            if (!awDone && s_axi_awready === 1'b1) begin
                awDone = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!wDone && s_axi_wready === 1'b1) begin
                wDone = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
        check(s_axi_bresp, er);
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge core_clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
        check(s_axi_rdata, exp);
        check(s_axi_rresp, er);
        s_axi_rready <= 1'b0;
    endtask

    task automatic pci(input logic [31:0] a, input logic io, input logic wr, input logic oth,
        input logic expClaim, input vme_attr_s ea);
        @(posedge core_clk);
        reqValid <= 1'b1;
        reqAddr <= a;
        reqIo <= io;
        reqWrite <= wr;
        otherImageHit <= oth;
        @(posedge core_clk);
        reqValid <= 1'b0;
        otherImageHit <= 1'b0;
        #1;
        check(claim, expClaim);
        if (expClaim) begin
            check(vmeAttr, ea);
        end
    endtask

    function automatic vme_attr_s attr(input logic [1:0] r, input logic a16,
        input logic [3:0] max_vme_width, program_data_select, sup, input logic posted);
        vme_attr_s e;
        e.wide = max_vme_width[r];
        e.a16 = a16;
        e.posted = posted;
        if (a16) e.am = sup[r] ? 6'h2d : 6'h29;
        else e.am = sup[r] ? (program_data_select[r] ? 6'h3e : 6'h3d) : (program_data_select[r] ? 6'h3a : 6'h39);
        return e;
    endfunction

    task automatic coupled(input logic [7:0] g);
        @(posedge core_clk);
        go <= 1'b1;
        gap <= g;
        @(posedge core_clk);
        go <= 1'b0;
        do begin @(posedge core_clk); #1; end while (coupledDone !== 1'b1);
    endtask

    task automatic hold(output int k);
        k = 0;
        do begin @(posedge core_clk); #1; k++; end while (vmeOwned === 1'b1 && k < 1100);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic test_regs();
        axi_read(`MISC_OFFSET, 32'h0, 2'h0);
        axi_read(`IMAGE_OFFSET, 32'h0, 2'h0);
        axi_write(`MISC_OFFSET, 32'hffff_ffff, 2'h0);
        axi_read(`MISC_OFFSET, 32'hf700_0000, 2'h0);
        axi_write(`IMAGE_OFFSET, 32'hffff_ffff, 2'h0);
        axi_read(`IMAGE_OFFSET, 32'hc0f0_fffd, 2'h0);
        axi_write(12'h18c, 32'h1234_5678, 2'h3);
        axi_read(12'h18c, 32'h0, 2'h3);
        axi_write(`IMAGE_OFFSET, 32'h0, 2'h0);
        axi_write(`MISC_OFFSET, 32'h0, 2'h0);
        $display("test_regs done");
    endtask

    task automatic test_decode();
        int r, h;
        vme_attr_s none;
        none = '0;
        axi_write(`IMAGE_OFFSET, 32'hc050_3aa8, 2'h0);
        for (r = 0; r < 4; r++) begin
            for (h = 0; h < 2; h++) begin
                pci({6'h2a, r[1:0], h[0] ? 8'hff : 8'hfe, 16'h1234}, 1'b0, 1'b1, 1'b0, 1'b1,
                    attr(r[1:0], h[0], 4'h5, 4'h3, 4'ha, 1'b1));
            end
        end
        pci(32'ha9ff_0000, 1'b0, 1'b0, 1'b0, 1'b1, attr(2'h1, 1'b1, 4'h5, 4'h3, 4'ha, 1'b0));
        pci(32'hac00_0000, 1'b0, 1'b1, 1'b0, 1'b0, none);
        pci(32'ha7ff_ffff, 1'b0, 1'b1, 1'b0, 1'b0, none);
        pci(32'ha800_0000, 1'b1, 1'b1, 1'b0, 1'b0, none);
        pci(32'ha800_0000, 1'b0, 1'b1, 1'b1, 1'b0, none);
        axi_write(`IMAGE_OFFSET, 32'hc050_3aa9, 2'h0);
        pci(32'hab00_0010, 1'b1, 1'b1, 1'b0, 1'b1, attr(2'h3, 1'b0, 4'h5, 4'h3, 4'ha, 1'b0));
        pci(32'hab00_0010, 1'b0, 1'b1, 1'b0, 1'b0, none);
        axi_write(`IMAGE_OFFSET, 32'h8050_3aa8, 2'h0);
        pci(32'ha800_0000, 1'b0, 1'b1, 1'b0, 1'b1, attr(2'h0, 1'b0, 4'h5, 4'h3, 4'ha, 1'b0));
        axi_write(`IMAGE_OFFSET, 32'h0050_3aa8, 2'h0);
        pci(32'ha800_0000, 1'b0, 1'b1, 1'b0, 1'b0, none);
        $display("test_decode done");
    endtask

    task automatic test_window();
        int c, k;
        // The image stays disabled here, so the misc register may be rewritten.
        for (c = 0; c < 8; c++) begin
            axi_write(`MISC_OFFSET, 32'h5000_0000 | (32'(c) << 24), 2'h0);
            coupled(8'h03);
            hold(k);
            check(k, (c == 0 || c == 7) ? 1 : (16 << (c - 1)) + 1);
        end
        axi_write(`MISC_OFFSET, 32'h0100_0000, 2'h0);
        coupled(8'h02);
        repeat (8) @(posedge core_clk);
        #1;
        check(vmeOwned, 1'b1);
        coupled(8'h04);
        hold(k);
        check(k, 17);
        $display("test_window done");
    endtask

    initial begin
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        test_regs();
        test_decode();
        test_window();
        wrap_up();
    end
endmodule

`default_nettype wire
